// ==== rtl/rai_alarm_update.sv ====
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
module rai_alarm_update
  import rai_pkg::*;
#(
  parameter int UPD_HOLD_CYC = RAI_UPD_HOLD_CYC
)(
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire rai_time_s   time_now,
  output logic             clock_stop,
  input  wire logic        int_pin_i,
  output logic             int_pin_o,
  output logic             int_pin_oe
);

  // ****************************************
  // register storage
  // ****************************************
  logic [7:0]  alm_sec_r;
  logic [7:0]  alm_min_r;
  logic [7:0]  alm_hour_r;
  logic [7:0]  alm_wday_r;
  logic [7:0]  ext_ctrl_r;
  logic [7:0]  irq_ctrl_r;
  logic        alarm_flag_r;
  logic        update_flag_r;
  logic        upd_req_r;
  logic [31:0] upd_cnt_r;
  logic        pin_s1_r;
  logic        pin_s2_r;
  logic [31:0] prdata_r;
  logic        pready_r;
  logic        pslverr_r;
  logic        int_oe_r;

  // ****************************************
  // bus decode
  // ****************************************
  logic       setup;
  logic       wr_en;
  logic [7:0] idx;
  logic       mapped;
  logic [7:0] wbyte;
  logic [7:0] rbyte;

  assign setup = psel && !penable && !pready_r;
  assign wr_en = psel && penable && pready_r && pwrite && !pslverr_r && pstrb[0];
  assign idx   = paddr[9:2];
  assign wbyte = pwdata[7:0];

  always_comb
  begin
    mapped = 1'b1;
    rbyte  = 8'h00;
    unique case (idx)
      RAI_IDX_ALM_SEC:  rbyte = alm_sec_r;
      RAI_IDX_ALM_MIN:  rbyte = alm_min_r;
      RAI_IDX_ALM_HOUR: rbyte = alm_hour_r;
      RAI_IDX_ALM_WDAY: rbyte = alm_wday_r;
      RAI_IDX_EXT_CTRL: rbyte = ext_ctrl_r;
      RAI_IDX_FLAGS:
      begin
        rbyte[RAI_BIT_UPDATE_FLAG] = update_flag_r;
        rbyte[RAI_BIT_ALARM_FLAG]  = alarm_flag_r;
      end
      RAI_IDX_IRQ_CTRL:
      begin
        rbyte                    = irq_ctrl_r;
        rbyte[RAI_BIT_PIN_LEVEL] = pin_s2_r;
      end
      default: mapped = 1'b0;
    endcase
    if (paddr[1:0] != 2'h0 || paddr[11:10] != 2'h0)
    begin
      mapped = 1'b0;
    end
  end

  // ****************************************
  // apb answer, no wait state
  // ****************************************
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end
    else
    begin
      pready_r  <= setup;
      pslverr_r <= setup && !mapped;
      if (setup)
      begin
        prdata_r <= (mapped && !pwrite) ? {24'h00_0000, rbyte} : 32'h0000_0000;
      end
    end
  end

  function automatic logic wr_hit(input logic [7:0] reg_idx);
    wr_hit = wr_en && (idx == reg_idx);
  endfunction

  // ****************************************
  // alarm fields and control
  // ****************************************
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      alm_sec_r  <= RAI_RST_ALARM;
      alm_min_r  <= RAI_RST_ALARM;
      alm_hour_r <= RAI_RST_ALARM;
      alm_wday_r <= RAI_RST_ALARM;
      ext_ctrl_r <= RAI_RST_EXT_CTRL;
      irq_ctrl_r <= RAI_RST_IRQ_CTRL;
    end
    else
    begin
      if (wr_hit(RAI_IDX_ALM_SEC))  alm_sec_r  <= wbyte;
      if (wr_hit(RAI_IDX_ALM_MIN))  alm_min_r  <= wbyte;
      if (wr_hit(RAI_IDX_ALM_HOUR)) alm_hour_r <= wbyte;
      if (wr_hit(RAI_IDX_ALM_WDAY)) alm_wday_r <= wbyte;
      if (wr_hit(RAI_IDX_EXT_CTRL)) ext_ctrl_r <= wbyte;
      if (wr_hit(RAI_IDX_IRQ_CTRL)) irq_ctrl_r <= wbyte & RAI_IRQ_CTRL_WMASK;
    end
  end

  // ****************************************
  // alarm match
  // ****************************************
  logic stopped;
  logic day_hit;
  logic alarm_match;
  logic alarm_event;
  logic update_event;

  assign stopped = irq_ctrl_r[RAI_BIT_CLOCK_STOP];

  always_comb
  begin
    if (alm_wday_r[RAI_BIT_FIELD_DISABLE])
    begin
      day_hit = 1'b1;
    end
    else if (ext_ctrl_r[RAI_BIT_WEEK_DAY_SELECT])
    begin
      day_hit = alm_wday_r[5:0] == time_now.date;
    end
    else
    begin
      day_hit = alm_wday_r[time_now.wday];
    end
  end

  assign alarm_match = day_hit
    && rai_field_hit(alm_hour_r, {1'b0, time_now.hour})
    && rai_field_hit(alm_min_r, time_now.min)
    && rai_field_hit(alm_sec_r, time_now.sec);

  // only checked on a second tick, so a write never fires it
  assign alarm_event  = time_now.sec_tick && alarm_match && !stopped;
  assign update_event = !stopped && (ext_ctrl_r[RAI_BIT_UPD_PERIOD_SEL] ?
    time_now.min_tick : time_now.sec_tick);

  // ****************************************
  // flags, set wins over clear
  // ****************************************
  logic flag_wr;

  assign flag_wr = wr_hit(RAI_IDX_FLAGS);

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      alarm_flag_r  <= 1'b0;
      update_flag_r <= 1'b0;
    end
    else
    begin
      if (alarm_event)
        alarm_flag_r <= 1'b1;
      else if (flag_wr && !wbyte[RAI_BIT_ALARM_FLAG])
        alarm_flag_r <= 1'b0;
      if (update_event)
        update_flag_r <= 1'b1;
      else if (flag_wr && !wbyte[RAI_BIT_UPDATE_FLAG])
        update_flag_r <= 1'b0;
    end
  end

  // ****************************************
  // update pin request with auto release
  // ****************************************
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      upd_req_r <= 1'b0;
      upd_cnt_r <= 32'h0000_0000;
    end
    else if (update_event)
    begin
      upd_req_r <= 1'b1;
      upd_cnt_r <= 32'(UPD_HOLD_CYC - 1);
    end
    else if (flag_wr && !wbyte[RAI_BIT_UPDATE_FLAG])
    begin
      upd_req_r <= 1'b0;
    end
    else if (upd_req_r)
    begin
      if (upd_cnt_r == 32'h0000_0000)
        upd_req_r <= 1'b0;
      else
        upd_cnt_r <= upd_cnt_r - 32'h0000_0001;
    end
  end

  // ****************************************
  // interrupt pin
  // ****************************************
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      int_oe_r <= 1'b0;
      pin_s1_r <= 1'b1;
      pin_s2_r <= 1'b1;
    end
    else
    begin
      int_oe_r <= (alarm_flag_r && irq_ctrl_r[RAI_BIT_ALM_IRQ_EN])
        || (upd_req_r && irq_ctrl_r[RAI_BIT_UPD_IRQ_EN]);
      pin_s1_r <= int_pin_i;
      pin_s2_r <= pin_s1_r;
    end
  end

  assign prdata     = prdata_r;
  assign pready     = pready_r;
  assign pslverr    = pslverr_r;
  assign clock_stop = stopped;
  assign int_pin_o  = 1'b0;
  assign int_pin_oe = int_oe_r;

endmodule

// ==== rtl/rai_pkg.sv ====
package rai_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] RAI_IDX_ALM_MIN  = 8'h17;
  localparam logic [7:0] RAI_IDX_ALM_HOUR = 8'h18;
  localparam logic [7:0] RAI_IDX_ALM_WDAY = 8'h19;
  localparam logic [7:0] RAI_IDX_EXT_CTRL = 8'h1D;
  localparam logic [7:0] RAI_IDX_FLAGS    = 8'h1E;
  localparam logic [7:0] RAI_IDX_IRQ_CTRL = 8'h1F;
  localparam logic [7:0] RAI_IDX_ALM_SEC  = 8'h2C;

  // field positions
  localparam int RAI_BIT_FIELD_DISABLE   = 7;
  localparam int RAI_BIT_UPD_PERIOD_SEL  = 5;
  localparam int RAI_BIT_WEEK_DAY_SELECT = 3;
  localparam int RAI_BIT_UPDATE_FLAG     = 5;
  localparam int RAI_BIT_ALARM_FLAG      = 3;
  localparam int RAI_BIT_UPD_IRQ_EN      = 5;
  localparam int RAI_BIT_ALM_IRQ_EN      = 3;
  localparam int RAI_BIT_PIN_LEVEL       = 6;
  localparam int RAI_BIT_CLOCK_STOP      = 0;

  // writable bits of the interrupt control register
  localparam logic [7:0] RAI_IRQ_CTRL_WMASK = 8'h3D;

  // reset values
  localparam logic [7:0] RAI_RST_ALARM    = 8'h00;
  localparam logic [7:0] RAI_RST_EXT_CTRL = 8'h00;
  localparam logic [7:0] RAI_RST_IRQ_CTRL = 8'h00;

  // timing
  localparam int RAI_CLK_MHZ          = 50;
  localparam int RAI_UPD_HOLD_US_X100 = 757000;
  localparam int RAI_UPD_HOLD_CYC     =
    (RAI_UPD_HOLD_US_X100 * RAI_CLK_MHZ + 99) / 100;

  // running time, all bcd except weekday (0 = sunday)
  typedef struct packed {
    logic       sec_tick;
    logic       min_tick;
    logic [6:0] sec;
    logic [6:0] min;
    logic [5:0] hour;
    logic [2:0] wday;
    logic [5:0] date;
  } rai_time_s;

  function automatic logic rai_field_hit(input logic [7:0] alarm, input logic [6:0] now);
    rai_field_hit = alarm[RAI_BIT_FIELD_DISABLE] || (alarm[6:0] == now);
  endfunction

endpackage

// ==== tb/rai_alarm_update_props.sv ====
`timescale 1ns/1ps
module rai_alarm_update_props
  import rai_pkg::*;
#(
  parameter int UPD_HOLD_CYC = RAI_UPD_HOLD_CYC
)(
  input wire logic        sys_clk,
  input wire logic        rst_b,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        clock_stop,
  input wire logic        int_pin_o,
  input wire logic        int_pin_oe
);
  logic [7:0] idx;
  logic       hit;
  assign idx = paddr[9:2];
  assign hit = paddr[1:0] == 2'h0 && paddr[11:10] == 2'h0 && (idx inside {RAI_IDX_ALM_MIN,
    RAI_IDX_ALM_HOUR, RAI_IDX_ALM_WDAY, RAI_IDX_EXT_CTRL, RAI_IDX_FLAGS, RAI_IDX_IRQ_CTRL,
    RAI_IDX_ALM_SEC});
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // ****************
  // bus and pin checks
  // ****************
  a_setup_ready: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_single: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_err_decode: assert property (psel && !penable |=> pslverr == $past(!hit))
    else $error("error response wrong for address");
  a_err_pair: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_rdata_upper: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("upper read data not zero");
  a_rdata_hold: assert property (!(psel && !penable) |=> $stable(prdata))
    else $error("read data moved outside setup");
  a_reset_quiet: assert property ($rose(rst_b) |-> !pready && !int_pin_oe && !clock_stop)
    else $error("outputs active out of reset");
  a_stop_quiet: assert property ((clock_stop && !int_pin_oe && !psel) [*3] |=> !int_pin_oe)
    else $error("pin driven while stopped");
  a_open_drain: assert property (int_pin_o == 1'b0)
    else $error("pin output level not low");
endmodule
bind rai_alarm_update rai_alarm_update_props #(.UPD_HOLD_CYC(UPD_HOLD_CYC)) u_props (.sys_clk,
  .rst_b, .psel, .penable, .paddr, .prdata, .pready, .pslverr, .clock_stop, .int_pin_o,
  .int_pin_oe);

// ==== tb/rai_alarm_update_tb.sv ====
`timescale 1ns/1ps
module rai_alarm_update_tb import rai_pkg::*;;
  localparam int HOLD = 20;
  logic        sys_clk, rst_b, psel, penable, pwrite, pready, pslverr, ev;
  logic        clock_stop, int_pin_i, int_pin_o, int_pin_oe;
  logic [3:0]  pstrb;
  logic [7:0]  rv;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  rai_time_s   time_now;
  int          bad_count, compares;
  rai_alarm_update #(.UPD_HOLD_CYC(HOLD)) u_dut (.sys_clk, .rst_b, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .time_now, .clock_stop, .int_pin_i,
    .int_pin_o, .int_pin_oe);
  rai_irq_host u_host (.int_pin_o, .int_pin_oe, .int_pin_i);
  // ****************
  // tasks
  // ****************
  task ck(input string n, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task ap(input logic w, input logic [7:0] i, input logic [7:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'h0, i, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    rv = prdata[7:0];
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task tk(input logic [6:0] s, input logic [2:0] w, input logic [5:0] d, input logic m);
    @(posedge sys_clk);
    time_now <= '{1'b1, m, s, 7'h00, 6'h07, w, d};
    @(posedge sys_clk);
    time_now.sec_tick <= 1'b0;
    time_now.min_tick <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask
  task pk(input logic e);
    ck("int_pin_oe", {7'h0, e}, {7'h0, int_pin_oe});
  endtask
  task fk(input logic [7:0] m, input logic [7:0] e);
    ap(0, RAI_IDX_FLAGS, 0);
    ck("event_flags", e, rv & m);
  endtask
  task complete_run;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // ****************
  // scenarios
  // ****************
  task t_regs;
    ap(0, RAI_IDX_EXT_CTRL, 0);
    ck("extension_control", 8'h00, rv);
    ap(0, RAI_IDX_IRQ_CTRL, 0);
    ck("interrupt_control", 8'h40, rv);
    ap(1, RAI_IDX_ALM_HOUR, 8'h5A);
    ap(0, RAI_IDX_ALM_HOUR, 0);
    ck("alarm_hour", 8'h5A, rv);
    ap(0, 8'h20, 0);
    ck("pslverr", 8'h01, {7'h0, ev});
  endtask
  task t_every;
    ap(1, RAI_IDX_ALM_SEC, 8'h80);
    ap(1, RAI_IDX_ALM_MIN, 8'h80);
    ap(1, RAI_IDX_ALM_HOUR, 8'h80);
    ap(1, RAI_IDX_ALM_WDAY, 8'h80);
    ap(1, RAI_IDX_IRQ_CTRL, 8'h08);
    tk(7'h12, 3'h1, 6'h01, 0);
    pk(1);
    ap(1, RAI_IDX_FLAGS, 8'hFF);
    fk(8'h08, 8'h08);
    ap(1, RAI_IDX_FLAGS, 8'h00);
    repeat (2) @(posedge sys_clk);
    pk(0);
    fk(8'h08, 8'h00);
  endtask
  task t_mask;
    ap(1, RAI_IDX_ALM_SEC, 8'h30);
    ap(1, RAI_IDX_ALM_WDAY, 8'h22);
    tk(7'h30, 3'h2, 6'h01, 0);
    fk(8'h08, 8'h00);
    tk(7'h30, 3'h5, 6'h01, 0);
    fk(8'h08, 8'h08);
    ap(1, RAI_IDX_FLAGS, 8'h00);
    ap(1, RAI_IDX_EXT_CTRL, 8'h08);
    ap(1, RAI_IDX_ALM_WDAY, 8'h15);
    tk(7'h30, 3'h0, 6'h15, 0);
    fk(8'h08, 8'h08);
    ap(1, RAI_IDX_FLAGS, 8'h00);
  endtask
  task t_gate;
    ap(1, RAI_IDX_IRQ_CTRL, 8'h00);
    tk(7'h30, 3'h0, 6'h15, 0);
    pk(0);
    fk(8'h08, 8'h08);
    ap(1, RAI_IDX_FLAGS, 8'h00);
    ap(1, RAI_IDX_ALM_SEC, 8'h30);
    repeat (3) @(posedge sys_clk);
    fk(8'h08, 8'h00);
  endtask
  task t_update;
    ap(1, RAI_IDX_EXT_CTRL, 8'h20);
    ap(1, RAI_IDX_IRQ_CTRL, 8'h20);
    tk(7'h01, 3'h0, 6'h00, 0);
    fk(8'h20, 8'h00);
    tk(7'h00, 3'h0, 6'h00, 1);
    pk(1);
    repeat (HOLD + 4) @(posedge sys_clk);
    pk(0);
    fk(8'h20, 8'h20);
    ap(1, RAI_IDX_FLAGS, 8'h00);
    tk(7'h00, 3'h0, 6'h00, 1);
    pk(1);
    ap(1, RAI_IDX_FLAGS, 8'h00);
    repeat (2) @(posedge sys_clk);
    pk(0);
    fk(8'h20, 8'h00);
  endtask
  task t_stop;
    ap(1, RAI_IDX_EXT_CTRL, 8'h00);
    ap(1, RAI_IDX_ALM_SEC, 8'h80);
    ap(1, RAI_IDX_ALM_WDAY, 8'h80);
    ap(1, RAI_IDX_IRQ_CTRL, 8'h29);
    tk(7'h05, 3'h0, 6'h00, 1);
    pk(0);
    fk(8'h28, 8'h00);
  endtask
  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  initial
  begin
    repeat (5000) @(posedge sys_clk);
    bad_count++;
    complete_run;
  end
  initial
  begin
    {rst_b, psel, penable, pwrite, paddr, pwdata} = '0;
    pstrb = 4'hF;
    time_now = '0;
    bad_count = 0;
    compares = 0;
    repeat (5) @(posedge sys_clk);
    rst_b <= 1'b1;
    t_regs;
    t_every;
    t_mask;
    t_gate;
    t_update;
    t_stop;
    complete_run;
  end
endmodule

// ==== tb/rai_irq_host.sv ====
`timescale 1ns/1ps
module rai_irq_host (
  input  wire logic int_pin_o,
  input  wire logic int_pin_oe,
  output logic      int_pin_i
);
  // pulled-up wire, low while the device drives it
  assign int_pin_i = int_pin_oe ? int_pin_o : 1'b1;
endmodule
